// [mmr_pkg.sv]
// Shared constants, types and checksum step for the monitor register interface.
package mmr_pkg;
  localparam logic [7:0]  FN_READ       = 8'h04;
  localparam logic [7:0]  FN_WRITE      = 8'h06;
  localparam logic [15:0] REG_PRODUCT   = 16'h0000;
  localparam logic [15:0] REG_OPTIONS   = 16'h0014;
  localparam logic [15:0] REG_ACTION    = 16'h0015;
  localparam logic [15:0] REG_FAULT     = 16'h001C;
  localparam logic [15:0] REG_STATE     = 16'h001E;
  localparam logic [15:0] REG_COND      = 16'h001F;
  localparam logic [15:0] REG_RES_FIRST = 16'h0038;
  localparam logic [15:0] REG_RES_LAST  = 16'h003F;
  localparam logic [15:0] MAX_READ      = 16'h007D;
  localparam logic [15:0] OPT_MASK      = 16'h019F;
  localparam logic [15:0] OPT_RESET     = 16'h0000;
  localparam int          OPT_SUPPRESS  = 8;
  localparam logic [15:0] CMD_START     = 16'h0001;
  localparam logic [15:0] CMD_REDO      = 16'h0002;
  localparam logic [15:0] CMD_R1_ON     = 16'h0003;
  localparam logic [15:0] CMD_R1_OFF    = 16'h0004;
  localparam logic [15:0] CMD_R2_ON     = 16'h0005;
  localparam logic [15:0] CMD_R2_OFF    = 16'h0006;
  localparam logic [15:0] CMD_EXER_ON   = 16'h0007;
  localparam logic [15:0] CMD_EXER_OFF  = 16'h0008;
  localparam logic [15:0] CMD_ABORT     = 16'h0009;
  localparam logic [15:0] CMD_LOG_ERASE = 16'h000A;
  localparam logic [15:0] CMD_LOG_END   = 16'h000B;
  localparam logic [15:0] CMD_LOG_PREV  = 16'h000C;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001;
  localparam logic [3:0]  RX_LAST       = 4'h7;
  localparam logic [3:0]  RX_CRC_HI     = 4'h6;
  localparam logic [7:0]  HEAD_RD_LEN   = 8'h03;
  localparam logic [7:0]  HEAD_WR_LEN   = 8'h06;
  localparam int          CLK_NS        = 4;
  localparam int          GAP_NS        = 4000;
  localparam int          GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam longint      REMOTE_MS     = 2000;
  localparam longint      REMOTE_CYC    = REMOTE_MS * 64'd1000000 / CLK_NS;
  localparam longint      BLINK_MS      = 250;
  localparam longint      BLINK_CYC     = BLINK_MS * 64'd1000000 / CLK_NS;
  typedef struct packed {
    logic start; logic redo_computation; logic abort;
    logic log_erase; logic log_seek_end; logic step_back_record;
  } mmr_act_t;
  typedef struct packed {
    logic heat_under_limit; logic water_under_limit; logic particles_under_limit;
    logic heat_over_limit; logic water_over_limit; logic particles_over_limit;
  } mmr_alarm_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_HEAD = 4'b0010, TX_DATA = 4'b0100, TX_CRC = 4'b1000
  } mmr_tx_t;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step
endpackage : mmr_pkg

// [mmr_fifo.sv]
// Byte FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module mmr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side.
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Drain side.
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  wire           push = in_valid_i && in_ready_o;
  wire           pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = count_reg != (AW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mmr_fifo

// [mmr_register_interface.sv]
// Register interface of the fluid monitor, answering read and write frames over a byte link.
//
// Functional notes
// - Option bits 0-4: continuous, auto start, stop clean, log every, confirm target.
// - Option bit 7 simulates results, bit 8 suppresses the particles low alarm; 5-6 reserved.
// - The option register resets to all zeros.
// - Writes to register 21 trigger actions and are never stored.
// - Command 1 starts or restarts a test; command 9 aborts it.
// - Command 7 enters self-exercise with LED flashing; command 8 leaves it.
// - Commands 2 to 6 and 10 to 12 perform their listed actions.
// - Register 30 reads the enumerated operating state.
// - Register 31 bits 0-2: outcome valid, new outcome, log outcome.
// - Register 31 bit 3 shows testing, bit 4 test complete.
// - Register 31 bits 5-10 show the six alarms and drive the relays.
// - Register 31 bit 11 shows remote control over the link.
// - Register 31 bits 12-14 mirror start input and both relays; bit 15 zero.
// - Register 28 holds five fault bits.
// - A fault bit holds until the next test end, clears only if gone.
// - Faults also show as a transient state code until a new start.
// - A read of 125 registers answers with a 255-byte frame.
// - Each register goes out as two bytes, high byte first.
// - Register 0 returns a fixed product code.
// - Registers 56 to 63 return the result codes.
// - Registers are 16 bits; wide values put upper half first.
`timescale 1ns/1ps
module mmr_register_interface #(
  parameter logic [15:0] PRODUCT_CODE     = 16'h1234,
  parameter logic [15:0] FAULT_STATE_CODE = 16'h00FF,
  parameter int unsigned REMOTE_HOLD_CYC  = 32'(mmr_pkg::REMOTE_CYC),
  parameter int unsigned BLINK_HALF_CYC   = 32'(mmr_pkg::BLINK_CYC),
  parameter int          FIFO_DEPTH       = 8
) (
  // Clock and reset.
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_I,
  // Received frame bytes.
  input  wire logic [7:0]        RX_DATA_I,
  input  wire logic              RX_VALID_I,
  // Answer frame bytes.
  output logic [7:0]             TX_DATA_O,
  output logic                   TX_VALID_O,
  input  wire logic              TX_READY_I,
  // Node address on the link.
  input  wire logic [7:0]        SLAVE_ADDR_I,
  // Measurement core state.
  input  wire logic              TEST_DONE_I,
  input  wire logic [4:0]        FAULT_COND_I,
  input  wire logic [15:0]       STATE_CODE_I,
  input  wire logic [2:0]        RESULT_FLAGS_I,
  input  wire mmr_pkg::mmr_alarm_t ALARM_I,
  input  wire logic [7:0][15:0]  RESULT_CODES_I,
  input  wire logic              BEGIN_INPUT_LEVEL_I,
  // Actions and controls toward the core.
  output mmr_pkg::mmr_act_t      ACTION_O,
  output logic [15:0]            TEST_OPTIONS_O,
  output logic                   TESTING_O,
  output logic                   EXERCISE_O,
  output logic                   LED_FLASH_O,
  output logic                   RELAY_ONE_LEVEL_O,
  output logic                   RELAY_TWO_LEVEL_O
);

  // Frame receiver state.
  logic [6:0][7:0] rx_buf_reg;
  logic [3:0]      rx_cnt_reg;
  logic [15:0]     rx_crc_reg;
  logic [15:0]     gap_cnt_reg;

  // Answer generator state.
  mmr_pkg::mmr_tx_t tx_state_reg;
  mmr_pkg::mmr_tx_t tx_state_next;
  logic [5:0][7:0] tx_head_reg;
  logic [7:0]      tx_head_len_reg;
  logic [7:0]      tx_idx_reg;
  logic [15:0]     tx_addr_reg;
  logic [7:0]      tx_left_reg;
  logic [15:0]     tx_crc_reg;
  logic [7:0]      tx_byte;

  // Device state.
  logic [15:0]     options_reg;
  mmr_pkg::mmr_act_t act_reg;
  logic            testing_reg;
  logic            complete_reg;
  logic [4:0]      fault_reg;
  logic            fault_code_reg;
  logic            exer_reg;
  logic            blink_reg;
  logic [31:0]     blink_cnt_reg;
  logic [31:0]     remote_cnt_reg;
  logic            frc1_on_reg;
  logic            frc1_off_reg;
  logic            frc2_on_reg;
  logic            frc2_off_reg;
  logic            relay1_reg;
  logic            relay2_reg;

  // Receiver decode.
  wire        tx_idle    = tx_state_reg == mmr_pkg::TX_IDLE;
  wire        rx_take    = RX_VALID_I && tx_idle;
  wire        frame_last = rx_take && (rx_cnt_reg == mmr_pkg::RX_LAST);
  wire        crc_good   = {rx_buf_reg[6], RX_DATA_I} == rx_crc_reg;
  wire        addr_hit   = rx_buf_reg[0] == SLAVE_ADDR_I;
  wire [7:0]  f_fn       = rx_buf_reg[1];
  wire [15:0] f_reg      = {rx_buf_reg[2], rx_buf_reg[3]};
  wire [15:0] f_val      = {rx_buf_reg[4], rx_buf_reg[5]};
  wire        frame_ok   = frame_last && crc_good && addr_hit;
  wire        is_read    = (f_fn == mmr_pkg::FN_READ) && (f_val != 16'h0000)
                           && (f_val <= mmr_pkg::MAX_READ);
  wire        rd_go      = frame_ok && is_read;
  wire        wr_go      = frame_ok && (f_fn == mmr_pkg::FN_WRITE);

  // Command decode; undefined values match no strobe and change nothing.
  wire wr_act    = wr_go && (f_reg == mmr_pkg::REG_ACTION);
  wire wr_opt    = wr_go && (f_reg == mmr_pkg::REG_OPTIONS);
  wire c_start   = wr_act && (f_val == mmr_pkg::CMD_START);
  wire c_abort   = wr_act && (f_val == mmr_pkg::CMD_ABORT);
  wire c_exer_on = wr_act && (f_val == mmr_pkg::CMD_EXER_ON);
  wire c_exer_of = wr_act && (f_val == mmr_pkg::CMD_EXER_OFF);
  wire c_r1_on   = wr_act && (f_val == mmr_pkg::CMD_R1_ON);
  wire c_r1_off  = wr_act && (f_val == mmr_pkg::CMD_R1_OFF);
  wire c_r2_on   = wr_act && (f_val == mmr_pkg::CMD_R2_ON);
  wire c_r2_off  = wr_act && (f_val == mmr_pkg::CMD_R2_OFF);

  mmr_pkg::mmr_act_t act_next;
  assign act_next.start            = c_start;
  assign act_next.redo_computation = wr_act && (f_val == mmr_pkg::CMD_REDO);
  assign act_next.abort            = c_abort;
  assign act_next.log_erase        = wr_act && (f_val == mmr_pkg::CMD_LOG_ERASE);
  assign act_next.log_seek_end     = wr_act && (f_val == mmr_pkg::CMD_LOG_END);
  assign act_next.step_back_record = wr_act && (f_val == mmr_pkg::CMD_LOG_PREV);

  // Alarm, relay and bitmap composition.
  mmr_pkg::mmr_alarm_t alarm_eff;
  assign alarm_eff.particles_over_limit  = ALARM_I.particles_over_limit;
  assign alarm_eff.water_over_limit      = ALARM_I.water_over_limit;
  assign alarm_eff.heat_over_limit       = ALARM_I.heat_over_limit;
  assign alarm_eff.particles_under_limit = ALARM_I.particles_under_limit
                                           && !options_reg[mmr_pkg::OPT_SUPPRESS];
  assign alarm_eff.water_under_limit     = ALARM_I.water_under_limit;
  assign alarm_eff.heat_under_limit      = ALARM_I.heat_under_limit;

  wire hi_alarm = alarm_eff.particles_over_limit || alarm_eff.water_over_limit
                  || alarm_eff.heat_over_limit;
  wire lo_alarm = alarm_eff.particles_under_limit || alarm_eff.water_under_limit
                  || alarm_eff.heat_under_limit;
  wire relay1_next = exer_reg ? blink_reg : frc1_on_reg ? 1'b1 : frc1_off_reg ? 1'b0 : hi_alarm;
  wire relay2_next = exer_reg ? !blink_reg : frc2_on_reg ? 1'b1 : frc2_off_reg ? 1'b0 : lo_alarm;
  wire remote      = remote_cnt_reg != 32'h0000_0000;
  wire blink_tick  = blink_cnt_reg == BLINK_HALF_CYC - 32'h0000_0001;

  wire [15:0] cond_word = {1'b0, relay2_reg, relay1_reg, BEGIN_INPUT_LEVEL_I,
                           remote,
                           alarm_eff,
                           complete_reg, testing_reg,
                           RESULT_FLAGS_I};
  wire [15:0] state_word = fault_code_reg ? FAULT_STATE_CODE : STATE_CODE_I;

  // Register read selection; unmapped and write-only registers read zero.
  wire        in_res  = (tx_addr_reg >= mmr_pkg::REG_RES_FIRST)
                        && (tx_addr_reg <= mmr_pkg::REG_RES_LAST);
  wire [15:0] rd_word =
      (tx_addr_reg == mmr_pkg::REG_PRODUCT) ? PRODUCT_CODE :
      (tx_addr_reg == mmr_pkg::REG_OPTIONS) ? options_reg :
      (tx_addr_reg == mmr_pkg::REG_FAULT)   ? {11'h000, fault_reg} :
      (tx_addr_reg == mmr_pkg::REG_STATE)   ? state_word :
      (tx_addr_reg == mmr_pkg::REG_COND)    ? cond_word :
      in_res ? RESULT_CODES_I[tx_addr_reg[2:0]] : 16'h0000;

  // Answer byte selection and FIFO handshake.
  wire tx_push;
  wire tx_ready;
  wire tx_fire = tx_push && tx_ready;
  assign tx_push = !tx_idle;

  always_comb begin
    case (tx_state_reg)
      mmr_pkg::TX_HEAD: tx_byte = tx_head_reg[tx_idx_reg[2:0]];
      mmr_pkg::TX_DATA: tx_byte = tx_idx_reg[0] ? rd_word[7:0] : rd_word[15:8];
      mmr_pkg::TX_CRC:  tx_byte = tx_idx_reg[0] ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
      default:          tx_byte = 8'h00;
    endcase
  end

  wire head_done = tx_idx_reg == tx_head_len_reg - 8'h01;
  wire data_done = tx_idx_reg[0] && (tx_left_reg == 8'h01);
  wire crc_done  = tx_idx_reg[0];

  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      mmr_pkg::TX_IDLE: begin
        if (rd_go || wr_go) tx_state_next = mmr_pkg::TX_HEAD;
      end
      mmr_pkg::TX_HEAD: begin
        if (tx_fire && head_done) begin
          tx_state_next = (tx_left_reg != 8'h00) ? mmr_pkg::TX_DATA : mmr_pkg::TX_CRC;
        end
      end
      mmr_pkg::TX_DATA: begin
        if (tx_fire && data_done) tx_state_next = mmr_pkg::TX_CRC;
      end
      mmr_pkg::TX_CRC: begin
        if (tx_fire && crc_done) tx_state_next = mmr_pkg::TX_IDLE;
      end
      default: tx_state_next = mmr_pkg::TX_IDLE;
    endcase
  end

  // Frame receiver; a silent gap mid-frame drops the partial frame.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rx_cnt_reg  <= 4'h0;
      rx_crc_reg  <= mmr_pkg::CRC_INIT;
      gap_cnt_reg <= 16'h0000;
      rx_buf_reg  <= '0;
    end else if (rx_take) begin
      gap_cnt_reg <= 16'h0000;
      rx_cnt_reg  <= frame_last ? 4'h0 : rx_cnt_reg + 4'h1;
      if (!frame_last) rx_buf_reg[rx_cnt_reg[2:0]] <= RX_DATA_I;
      if (rx_cnt_reg == 4'h0) begin
        rx_crc_reg <= mmr_pkg::crc_step(mmr_pkg::CRC_INIT, RX_DATA_I);
      end else if (rx_cnt_reg < mmr_pkg::RX_CRC_HI) begin
        rx_crc_reg <= mmr_pkg::crc_step(rx_crc_reg, RX_DATA_I);
      end
    end else if (rx_cnt_reg != 4'h0) begin
      gap_cnt_reg <= gap_cnt_reg + 16'h0001;
      if (gap_cnt_reg == 16'(mmr_pkg::GAP_CYC - 1)) begin
        rx_cnt_reg  <= 4'h0;
        gap_cnt_reg <= 16'h0000;
      end
    end
  end

  // Answer generator sequencing; stalls whenever the FIFO is full.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tx_state_reg    <= mmr_pkg::TX_IDLE;
      tx_idx_reg      <= 8'h00;
      tx_head_reg     <= '0;
      tx_head_len_reg <= mmr_pkg::HEAD_RD_LEN;
      tx_addr_reg     <= 16'h0000;
      tx_left_reg     <= 8'h00;
      tx_crc_reg      <= mmr_pkg::CRC_INIT;
    end else begin
      tx_state_reg <= tx_state_next;
      if (rd_go) begin
        tx_head_reg     <= {24'h000000, f_val[6:0], 1'b0, f_fn, rx_buf_reg[0]};
        tx_head_len_reg <= mmr_pkg::HEAD_RD_LEN;
        tx_addr_reg     <= f_reg;
        tx_left_reg     <= f_val[7:0];
        tx_idx_reg      <= 8'h00;
        tx_crc_reg      <= mmr_pkg::CRC_INIT;
      end else if (wr_go) begin
        tx_head_reg     <= rx_buf_reg[5:0];
        tx_head_len_reg <= mmr_pkg::HEAD_WR_LEN;
        tx_left_reg     <= 8'h00;
        tx_idx_reg      <= 8'h00;
        tx_crc_reg      <= mmr_pkg::CRC_INIT;
      end else if (tx_fire) begin
        tx_idx_reg <= (tx_state_next != tx_state_reg) ? 8'h00 : tx_idx_reg + 8'h01;
        if (tx_state_reg != mmr_pkg::TX_CRC) begin
          tx_crc_reg <= mmr_pkg::crc_step(tx_crc_reg, tx_byte);
        end
        if (tx_state_reg == mmr_pkg::TX_DATA && tx_idx_reg[0]) begin
          tx_addr_reg <= tx_addr_reg + 16'h0001;
          tx_left_reg <= tx_left_reg - 8'h01;
        end
      end
    end
  end

  // Options and action strobes.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      options_reg <= mmr_pkg::OPT_RESET;
      act_reg     <= '0;
    end else begin
      act_reg <= act_next;
      if (wr_opt) options_reg <= f_val & mmr_pkg::OPT_MASK;
    end
  end

  // Test progress, faults and the transient fault state code.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      testing_reg    <= 1'b0;
      complete_reg   <= 1'b0;
      fault_reg      <= 5'h00;
      fault_code_reg <= 1'b0;
    end else begin
      if (c_start) begin
        testing_reg    <= 1'b1;
        complete_reg   <= 1'b0;
        fault_code_reg <= 1'b0;
      end else if (c_abort) begin
        testing_reg <= 1'b0;
      end else if (TEST_DONE_I && testing_reg) begin
        testing_reg    <= 1'b0;
        complete_reg   <= 1'b1;
        fault_code_reg <= (fault_reg | FAULT_COND_I) != 5'h00;
      end
      if (TEST_DONE_I && testing_reg && !c_start && !c_abort) begin
        fault_reg <= FAULT_COND_I;
      end else begin
        fault_reg <= fault_reg | FAULT_COND_I;
      end
    end
  end

  // Relay overrides and self-exercise mode.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      frc1_on_reg  <= 1'b0;
      frc1_off_reg <= 1'b0;
      frc2_on_reg  <= 1'b0;
      frc2_off_reg <= 1'b0;
      exer_reg     <= 1'b0;
    end else begin
      if (c_r1_on || c_r1_off) begin
        frc1_on_reg  <= c_r1_on;
        frc1_off_reg <= c_r1_off;
      end
      if (c_r2_on || c_r2_off) begin
        frc2_on_reg  <= c_r2_on;
        frc2_off_reg <= c_r2_off;
      end
      if (c_exer_on) exer_reg <= 1'b1;
      else if (c_exer_of) exer_reg <= 1'b0;
    end
  end

  // Flash divider, relays and remote-control hold time.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      blink_cnt_reg  <= 32'h0000_0000;
      blink_reg      <= 1'b0;
      remote_cnt_reg <= 32'h0000_0000;
      relay1_reg     <= 1'b0;
      relay2_reg     <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_tick ? 32'h0000_0000 : blink_cnt_reg + 32'h0000_0001;
      if (!exer_reg || c_exer_of) blink_reg <= 1'b0;
      else if (blink_tick) blink_reg <= !blink_reg;
      if (frame_ok) remote_cnt_reg <= REMOTE_HOLD_CYC;
      else if (remote) remote_cnt_reg <= remote_cnt_reg - 32'h0000_0001;
      relay1_reg <= relay1_next;
      relay2_reg <= relay2_next;
    end
  end

  mmr_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i       (CLK_SYS_I),
    .rst_i       (RST_I),
    .in_data_i   (tx_byte),
    .in_valid_i  (tx_push),
    .in_ready_o  (tx_ready),
    .out_data_o  (TX_DATA_O),
    .out_valid_o (TX_VALID_O),
    .out_ready_i (TX_READY_I)
  );

  assign ACTION_O          = act_reg;
  assign TEST_OPTIONS_O    = options_reg;
  assign TESTING_O         = testing_reg;
  assign EXERCISE_O        = exer_reg;
  assign LED_FLASH_O       = blink_reg;
  assign RELAY_ONE_LEVEL_O = relay1_reg;
  assign RELAY_TWO_LEVEL_O = relay2_reg;

endmodule : mmr_register_interface

// [mmr_register_interface_assertions.sv]
// Concurrent checks on the register interface ports.
`timescale 1ns/1ps
module mmr_register_interface_assertions (
  // Watched ports.
  input wire logic              CLK_SYS_I,
  input wire logic              RST_I,
  input wire logic [7:0]        TX_DATA_O,
  input wire logic              TX_VALID_O,
  input wire logic              TX_READY_I,
  input wire logic              TEST_DONE_I,
  input wire mmr_pkg::mmr_act_t ACTION_O,
  input wire logic [15:0]       TEST_OPTIONS_O,
  input wire logic              TESTING_O,
  input wire logic              EXERCISE_O,
  input wire logic              LED_FLASH_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  a_tx_holds: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_DATA_O))
    else $error("answer byte changed before it was taken");
  a_opt_reserved: assert property ((TEST_OPTIONS_O & 16'hFE60) == 16'h0000)
    else $error("reserved option bit set");
  a_act_onehot: assert property ($onehot0(ACTION_O))
    else $error("two actions at once");
  a_act_pulse: assert property (|ACTION_O |=> ACTION_O == 6'h00)
    else $error("action longer than one cycle");
  a_start_test: assert property (ACTION_O.start |-> TESTING_O)
    else $error("start without testing");
  a_abort_stops: assert property (ACTION_O.abort |-> !TESTING_O)
    else $error("abort left testing");
  a_led_exercise: assert property (LED_FLASH_O |-> EXERCISE_O)
    else $error("flash outside exercise");
  a_done_ends: assert property (TESTING_O && TEST_DONE_I |=> !TESTING_O || ACTION_O.start)
    else $error("test did not end");
  a_reset_clear: assert property (disable iff (1'b0)
    RST_I |=> !TX_VALID_O && TEST_OPTIONS_O == 16'h0000 && ACTION_O == 6'h00)
    else $error("reset left outputs set");
  c_start: cover property (ACTION_O.start);
  c_stall: cover property (TX_VALID_O && !TX_READY_I);
  c_flash: cover property (LED_FLASH_O);
endmodule : mmr_register_interface_assertions
bind mmr_register_interface mmr_register_interface_assertions chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O),
  .TX_READY_I(TX_READY_I), .TEST_DONE_I(TEST_DONE_I), .ACTION_O(ACTION_O),
  .TEST_OPTIONS_O(TEST_OPTIONS_O), .TESTING_O(TESTING_O), .EXERCISE_O(EXERCISE_O),
  .LED_FLASH_O(LED_FLASH_O));

// [mmr_master_model.sv]
// Link master model: sends request frames and collects answer bytes.
`timescale 1ns/1ps
module mmr_master_model (
  // Clock and request side.
  input  wire logic       clk_i,
  output logic [7:0]      req_data_o,
  output logic            req_valid_o,
  // Answer side.
  input  wire logic [7:0] ans_data_i,
  input  wire logic       ans_valid_i,
  output logic            ans_ready_o
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  logic [1:0] tick = 2'h0;
  initial begin
    req_data_o = 8'h00;
    req_valid_o = 1'b0;
  end
  // A slow master is ready for an answer byte only one cycle in four.
  assign ans_ready_o = !slow || tick == 2'h3;
  always @(posedge clk_i) begin
    tick <= tick + 2'h1;
    if (ans_valid_i && ans_ready_o) got.push_back(ans_data_i);
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$], input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [7:0] a, f, input logic [15:0] r, v, input logic bad);
    logic [7:0]  fr[$];
    logic [15:0] c;
    fr = '{a, f, r[15:8], r[7:0], v[15:8], v[7:0]};
    c = crc16(fr, 6) ^ {15'h0000, bad};
    fr.push_back(c[15:8]);
    fr.push_back(c[7:0]);
    for (int i = 0; i < 8; i++) begin
      req_data_o <= fr[i];
      req_valid_o <= 1'b1;
      @(posedge clk_i);
    end
    req_data_o <= ~fr[7];
    req_valid_o <= 1'b0;
  endtask : send
endmodule : mmr_master_model

// [mmr_register_interface_tb.sv]
// Self-checking bench for the monitor register interface.
`timescale 1ns/1ps
module mmr_register_interface_tb;
  localparam logic [7:0]  ADDR = 8'h5A;
  localparam logic [15:0] PCODE = 16'h1234;
  localparam logic [3:0]  CMDS[13] = '{4'h1, 4'h2, 4'h7, 4'h8, 4'h3, 4'h5, 4'h4, 4'h6,
                                       4'hA, 4'hB, 4'hC, 4'h9, 4'hD};
  localparam logic [5:0]  ACTS[13] = '{6'h20, 6'h10, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
                                       6'h00, 6'h04, 6'h02, 6'h01, 6'h08, 6'h00};
  localparam logic [3:0]  LEVS[13] = '{4'h8, 4'h8, 4'hC, 4'h8, 4'hA, 4'hB, 4'h9, 4'h8,
                                       4'h8, 4'h8, 4'h8, 4'h0, 4'h0};
  logic                clk = 1'b0, rst = 1'b1, done = 1'b0;
  logic [4:0]          fault = 5'h00;
  logic [2:0]          flags = 3'h5;
  logic [7:0][15:0]    codes;
  logic [7:0]          rx_data, tx_data;
  logic                rx_valid, tx_valid, tx_ready, testing, exer, r1, r2, lvl = 1'b1;
  logic [15:0]         opts;
  mmr_pkg::mmr_alarm_t alarm = 6'h00;
  mmr_pkg::mmr_act_t   act, acts[$];
  int                  bad_count = 0, cmp_count = 0, cyc = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (|act) acts.push_back(act);
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  mmr_register_interface #(.PRODUCT_CODE(PCODE), .REMOTE_HOLD_CYC(2000), .BLINK_HALF_CYC(4))
    dut_u (.CLK_SYS_I(clk), .RST_I(rst), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .SLAVE_ADDR_I(ADDR),
    .TEST_DONE_I(done), .FAULT_COND_I(fault), .STATE_CODE_I(16'h0042),
    .RESULT_FLAGS_I(flags), .ALARM_I(alarm), .RESULT_CODES_I(codes), .BEGIN_INPUT_LEVEL_I(lvl),
    .ACTION_O(act), .TEST_OPTIONS_O(opts), .TESTING_O(testing), .EXERCISE_O(exer),
    .LED_FLASH_O(), .RELAY_ONE_LEVEL_O(r1), .RELAY_TWO_LEVEL_O(r2));
  mmr_master_model master_u (.clk_i(clk), .req_data_o(rx_data), .req_valid_o(rx_valid),
    .ans_data_i(tx_data), .ans_valid_i(tx_valid), .ans_ready_o(tx_ready));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] wd(input int i);
    return {master_u.got[3 + 2 * i], master_u.got[4 + 2 * i]};
  endfunction : wd
  // Sends one frame and waits for an answer of n bytes, none when refused.
  task automatic xfer(input logic [7:0] a, f, input logic [15:0] r, v, input int n,
                      input logic bad);
    master_u.got.delete();
    master_u.send(a, f, r, v, bad);
    repeat (2000) if (master_u.got.size() < n) @(posedge clk);
    repeat (n == 0 ? 40 : 4) @(posedge clk);
    chk(16'(master_u.got.size()), 16'(n));
    if (n > 0) chk({master_u.got[n-2], master_u.got[n-1]}, master_u.crc16(master_u.got, n-2));
  endtask : xfer
  task automatic rd(input logic [15:0] r, exp);
    xfer(ADDR, mmr_pkg::FN_READ, r, 16'h0001, 7, 1'b0);
    chk(wd(0), exp);
  endtask : rd
  task automatic wr(input logic [15:0] r, v);
    xfer(ADDR, mmr_pkg::FN_WRITE, r, v, 8, 1'b0);
  endtask : wr
  task automatic end_test();
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask : end_test
  initial begin
    for (int i = 0; i < 8; i++) codes[i] <= 16'hA0 + 16'(i);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(mmr_pkg::REG_PRODUCT, PCODE);
    rd(mmr_pkg::REG_OPTIONS, 16'h0000);
    master_u.slow <= 1'b1;
    xfer(ADDR, mmr_pkg::FN_READ, 16'h0000, 16'h007D, 255, 1'b0);
    master_u.slow <= 1'b0;
    chk({master_u.got[1], master_u.got[2]}, 16'h04FA);
    chk(wd(0), PCODE);
    chk(wd(21), 16'h0000);
    for (int i = 0; i < 8; i++) chk(wd(56 + i), codes[i]);
    wr(mmr_pkg::REG_OPTIONS, 16'hFFFF);
    rd(mmr_pkg::REG_OPTIONS, 16'h019F);
    chk(opts, 16'h019F);
    for (int i = 0; i < 13; i++) begin
      acts.delete();
      wr(mmr_pkg::REG_ACTION, {12'h000, CMDS[i]});
      chk({8'(acts.size()), 2'b00, acts.size() > 0 ? acts[0] : 6'h00},
          {7'h00, ACTS[i] != 6'h00, 2'b00, ACTS[i]});
      chk({12'h000, testing, exer, r1 & !exer, r2 & !exer}, {12'h000, LEVS[i]});
    end
    alarm <= 6'h2A;
    fault <= 5'h03;
    wr(mmr_pkg::REG_ACTION, mmr_pkg::CMD_START);
    rd(mmr_pkg::REG_COND, 16'h1C4D);
    rd(mmr_pkg::REG_STATE, 16'h0042);
    end_test();
    fault <= 5'h00;
    lvl <= 1'b0;
    rd(mmr_pkg::REG_FAULT, 16'h0003);
    rd(mmr_pkg::REG_STATE, 16'h00FF);
    rd(mmr_pkg::REG_COND, 16'h0C55);
    wr(mmr_pkg::REG_ACTION, mmr_pkg::CMD_START);
    rd(mmr_pkg::REG_STATE, 16'h0042);
    rd(mmr_pkg::REG_FAULT, 16'h0003);
    end_test();
    rd(mmr_pkg::REG_FAULT, 16'h0000);
    xfer(ADDR, mmr_pkg::FN_READ, 16'h0000, 16'h0001, 0, 1'b1);
    xfer(8'h5B, mmr_pkg::FN_READ, 16'h0000, 16'h0001, 0, 1'b0);
    xfer(ADDR, mmr_pkg::FN_READ, 16'h0000, 16'h007E, 0, 1'b0);
    rd(mmr_pkg::REG_PRODUCT, PCODE);
    stop_test();
  end
endmodule : mmr_register_interface_tb
